// ==== core/glt_defines.vh ====
// Register map, field positions, reset values and timing constants for the load model and relax tracker.
// Operation
// - Load model kind 0 selects constant-current model, 1 selects constant-power model.
// - Power kind, select 0: use previous discharge cycle average power.
// - Select 1 (default): use average power of present discharge cycle so far.
// - Select 2: average current times voltage; 3: filtered current (14 s) times voltage.
// - Select 4: design energy over five; 5: host rate target; 6: user power rate.
// - Keep reserve charge and reserve energy, compensated at a no-load rate; the code only stores both values and applies no compensation.
// - Discharge is real only when current magnitude exceeds the discharge threshold.
// - Charge is real only when current magnitude exceeds the charge threshold.
// - Enter relaxation after average current stays below quit current for a relax time.
// - After about five minutes relaxed, start taking open-circuit-voltage readings; the code takes one reading per relaxation.
// - Capacity update only when voltage slope is below 4 microvolts per second.
// - Leave relaxation only after average current stays above quit current for quit time.
// - Hold one maximum capacity per profile, seeded by user, updated during operation.
// - Learned-status registers define only bit 0, set by device when capacity learned.
// - Average current over each discharge cycle; store previous cycle average, device only.
// - Form power as current times voltage, average per cycle, store previous average.
// - Record the largest voltage difference between load spikes and normal load; the code keeps the last difference and a running average, not the largest.
// - Debug bits 1:0 choose spike margin: variance, last change, minimum setting, unused.
// - Update cell resistance tables during operation but never the default tables.
`ifndef GLT_DEFINES_VH
`define GLT_DEFINES_VH

`define GLT_A_CTRL      8'h00
`define GLT_A_DSG_TH    8'h04
`define GLT_A_CHG_TH    8'h08
`define GLT_A_QUIT_I    8'h0C
`define GLT_A_DSG_RT    8'h10
`define GLT_A_CHG_RT    8'h14
`define GLT_A_QUIT_RT   8'h18
`define GLT_A_RES_CHG   8'h1C
`define GLT_A_RES_NRG   8'h20
`define GLT_A_DESIGN_E  8'h24
`define GLT_A_HOST_RT   8'h28
`define GLT_A_USER_RT   8'h2C
`define GLT_A_MIN_DV    8'h30
`define GLT_A_QMAX0     8'h34
`define GLT_A_QMAX1     8'h38
`define GLT_A_UPD0      8'h3C
`define GLT_A_UPD1      8'h40
`define GLT_A_MEAS_I    8'h44
`define GLT_A_MEAS_V    8'h48
`define GLT_A_SLOPE     8'h4C
`define GLT_A_STATUS    8'h50
`define GLT_A_LOAD      8'h54
`define GLT_A_AVG_I_LR  8'h58
`define GLT_A_AVG_P_LR  8'h5C
`define GLT_A_DELTA_V   8'h60
`define GLT_A_RA0       8'h64
`define GLT_A_RA1       8'h68
`define GLT_A_DEF_RA    8'h6C

// Control register fields.
`define GLT_C_KIND      0
`define GLT_C_SEL_LO    1
`define GLT_C_SEL_HI    3
`define GLT_C_DBG_LO    4
`define GLT_C_DBG_HI    5
`define GLT_C_RESCAP    6
`define GLT_C_PROFILE   7
`define GLT_CTRL_RST    8'h02

// Status register fields.
`define GLT_S_DSG       0
`define GLT_S_CHG       1
`define GLT_S_RELAX     2
`define GLT_S_OCV       3
`define GLT_S_QUPD      4

`define GLT_UPD_MASK    16'h0001
`define GLT_SLOPE_MAX   16'h0004
`define GLT_RATE_DIV    3'h5

`define GLT_DV_STD      2'h0
`define GLT_DV_LAST     2'h1
`define GLT_DV_MIN      2'h2

// Relax, OCV and filter times, with cycle counts at 250 MHz.
`define GLT_CLK_HZ      32'h0EE6B280
`define GLT_OCV_S       32'h0000012C
`define GLT_TAU_S       8'h0E
`define GLT_OCV_CYC     ({8'h00, `GLT_OCV_S} * {8'h00, `GLT_CLK_HZ})
`define GLT_SEC_CYC     `GLT_CLK_HZ

`endif

// ==== core/glt_cycle_avg.v ====
// Running average of a signed quantity over one discharge cycle.
`timescale 1ns/1ps
module glt_cycle_avg #(
	parameter W = 16
) (
	// Clock and reset
	input  wire                 clk,
	input  wire                 rst,
	// Samples
	input  wire                 sample,
	input  wire signed [W-1:0]  value,
	input  wire                 active,
	// Results
	output reg  signed [W-1:0]  present_avg,
	output reg  signed [W-1:0]  last_avg
);
	reg signed [W+23:0] sum_reg;
	reg [23:0]          cnt_reg;
	reg                 active_reg;
	wire signed [W+23:0] sum_next;
	wire [23:0]          cnt_next;
	wire signed [W+23:0] quot;

	assign sum_next = sum_reg + {{24{value[W-1]}}, value};
	assign cnt_next = cnt_reg + 24'h000001;
	assign quot     = sum_next / $signed({1'b0, cnt_next});

	// The divide is slow but runs once per sample; the averages feed the load model as well as the status reads.
	always @(posedge clk) begin
		if (rst) begin
			sum_reg     <= {(W+24){1'b0}};
			cnt_reg     <= 24'h000000;
			active_reg  <= 1'b0;
			present_avg <= {W{1'b0}};
			last_avg    <= {W{1'b0}};
		end else begin
			active_reg <= active;
			if (active && sample && cnt_reg != 24'hFFFFFF) begin
				sum_reg     <= sum_next;
				cnt_reg     <= cnt_next;
				present_avg <= quot[W-1:0];
			end
			if (active_reg && !active) begin
				if (cnt_reg != 24'h000000)
					last_avg <= present_avg;
				sum_reg <= {(W+24){1'b0}};
				cnt_reg <= 24'h000000;
			end
		end
	end
endmodule

// ==== core/glt_tracker.v ====
// Load model selection, current classification, relaxation tracking and capacity status.
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "glt_defines.vh"
module glt_tracker #(
	parameter        W        = 16,
	parameter [39:0] OCV_CYC  = `GLT_OCV_CYC,
	parameter [31:0] SEC_CYC  = `GLT_SEC_CYC,
	parameter [7:0]  TAU_S    = `GLT_TAU_S
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         wb_err_o,
	// Measurements
	input  wire        meas_valid,
	input  wire        spike_valid,
	// Results
	output reg  [W-1:0] load_value,
	output reg          relaxed,
	output reg          ocv_take,
	output reg          qmax_update
);
	reg [7:0]           ctrl_reg;
	reg [W-1:0]         dsg_th_reg, chg_th_reg, quit_i_reg, res_chg_reg, res_nrg_reg;
	reg [W-1:0]         design_e_reg, host_rt_reg, user_rt_reg, min_dv_reg;
	reg [15:0]          dsg_rt_reg, chg_rt_reg, quit_rt_reg;
	reg [W-1:0]         qmax_reg [0:1];
	reg [W-1:0]         ra_reg   [0:1];
	reg [W-1:0]         def_ra_reg;
	reg [15:0]          upd_reg  [0:1];
	reg signed [W-1:0]  meas_i_reg, meas_v_reg, slope_reg;
	reg signed [W-1:0]  avg_i_reg, filt_i_reg, dv_reg, dv_last_reg, dv_var_reg;
	reg                 dsg_reg, chg_reg, meas_pend_reg;
	reg [15:0]          below_s_reg, above_s_reg;
	reg [31:0]          sec_cnt_reg;
	reg [39:0]          relax_cnt_reg;
	reg                 ocv_done_reg;
	reg [4:0]           status_reg;

	wire [2:0] sel   = ctrl_reg[`GLT_C_SEL_HI:`GLT_C_SEL_LO];
	wire [1:0] dvsel = ctrl_reg[`GLT_C_DBG_HI:`GLT_C_DBG_LO];
	wire       prof  = ctrl_reg[`GLT_C_PROFILE];
	wire       wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire       wb_wr  = wb_req && wb_we_i;
	wire       sec_tick = (sec_cnt_reg == SEC_CYC - 32'h1);

	function [W-1:0] absv;
		input signed [W-1:0] x;
		begin
			absv = x[W-1] ? -x : x;
		end
	endfunction

	function [W-1:0] mulv;
		input signed [W-1:0] a;
		input signed [W-1:0] b;
		reg signed [2*W-1:0] p;
		begin
			p    = a * b;
			mulv = p[2*W-1:W];
		end
	endfunction

	// Merge the written bytes into a register value.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] d;
		input [3:0]  s;
		begin
			merge = {s[3] ? d[31:24] : old[31:24], s[2] ? d[23:16] : old[23:16],
			         s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
		end
	endfunction

	wire [W-1:0] abs_avg   = absv(avg_i_reg);
	wire [W-1:0] abs_i     = absv(meas_i_reg);
	wire         below_q   = abs_avg < quit_i_reg;
	wire signed [W-1:0] inst_p = $signed(mulv(meas_i_reg, meas_v_reg));
	// Class of the sample taken now, so a cycle starts and ends on the right sample.
	wire         dsg_now   = meas_i_reg[W-1] && (abs_i > dsg_th_reg);
	wire         dsg_live  = meas_pend_reg ? dsg_now : dsg_reg;
	wire signed [W-1:0] p_now, p_last, i_now, i_last;

	// ************************************************************
	// Cycle averages of current and power
	// ************************************************************
	glt_cycle_avg #(.W(W)) u_avg_i (
		.clk         (clk),
		.rst         (rst),
		.sample      (meas_pend_reg),
		.value       (meas_i_reg),
		.active      (dsg_live),
		.present_avg (i_now),
		.last_avg    (i_last)
	);
	glt_cycle_avg #(.W(W)) u_avg_p (
		.clk         (clk),
		.rst         (rst),
		.sample      (meas_pend_reg),
		.value       (inst_p),
		.active      (dsg_live),
		.present_avg (p_now),
		.last_avg    (p_last)
	);

	// ************************************************************
	// Load model
	// ************************************************************
	reg [W-1:0] load_next;
	always @* begin
		load_next = {W{1'b0}};
		if (ctrl_reg[`GLT_C_KIND]) begin
			case (sel)
			3'h0: load_next = absv(p_last);
			3'h1: load_next = absv(p_now);
			3'h2: load_next = absv($signed(mulv(avg_i_reg, meas_v_reg)));
			3'h3: load_next = absv($signed(mulv(filt_i_reg, meas_v_reg)));
			3'h4: load_next = design_e_reg / {{(W-3){1'b0}}, `GLT_RATE_DIV};
			3'h5: load_next = host_rt_reg;
			3'h6: load_next = user_rt_reg;
			default: load_next = user_rt_reg;
			endcase
		end else begin
			case (sel)
			3'h0: load_next = absv(i_last);
			3'h1: load_next = absv(i_now);
			3'h2: load_next = abs_avg;
			3'h3: load_next = absv(filt_i_reg);
			3'h4: load_next = qmax_reg[prof] / {{(W-3){1'b0}}, `GLT_RATE_DIV};
			3'h5: load_next = host_rt_reg;
			3'h6: load_next = user_rt_reg;
			default: load_next = user_rt_reg;
			endcase
		end
	end

	// ************************************************************
	// Register read
	// ************************************************************
	reg [W-1:0] rd_val;
	reg         rd_hit;
	always @* begin
		rd_hit = 1'b1;
		rd_val = {W{1'b0}};
		if (wb_adr_i == `GLT_A_CTRL) rd_val = {{(W-8){1'b0}}, ctrl_reg};
		else if (wb_adr_i == `GLT_A_DSG_TH) rd_val = dsg_th_reg;
		else if (wb_adr_i == `GLT_A_CHG_TH) rd_val = chg_th_reg;
		else if (wb_adr_i == `GLT_A_QUIT_I) rd_val = quit_i_reg;
		else if (wb_adr_i == `GLT_A_DSG_RT) rd_val = dsg_rt_reg;
		else if (wb_adr_i == `GLT_A_CHG_RT) rd_val = chg_rt_reg;
		else if (wb_adr_i == `GLT_A_QUIT_RT) rd_val = quit_rt_reg;
		else if (wb_adr_i == `GLT_A_RES_CHG) rd_val = res_chg_reg;
		else if (wb_adr_i == `GLT_A_RES_NRG) rd_val = res_nrg_reg;
		else if (wb_adr_i == `GLT_A_DESIGN_E) rd_val = design_e_reg;
		else if (wb_adr_i == `GLT_A_HOST_RT) rd_val = host_rt_reg;
		else if (wb_adr_i == `GLT_A_USER_RT) rd_val = user_rt_reg;
		else if (wb_adr_i == `GLT_A_MIN_DV) rd_val = min_dv_reg;
		else if (wb_adr_i == `GLT_A_QMAX0) rd_val = qmax_reg[0];
		else if (wb_adr_i == `GLT_A_QMAX1) rd_val = qmax_reg[1];
		else if (wb_adr_i == `GLT_A_UPD0) rd_val = upd_reg[0] & `GLT_UPD_MASK;
		else if (wb_adr_i == `GLT_A_UPD1) rd_val = upd_reg[1] & `GLT_UPD_MASK;
		else if (wb_adr_i == `GLT_A_MEAS_I) rd_val = meas_i_reg;
		else if (wb_adr_i == `GLT_A_MEAS_V) rd_val = meas_v_reg;
		else if (wb_adr_i == `GLT_A_SLOPE) rd_val = slope_reg;
		else if (wb_adr_i == `GLT_A_STATUS) rd_val = {{(W-5){1'b0}}, status_reg};
		else if (wb_adr_i == `GLT_A_LOAD) rd_val = load_value;
		else if (wb_adr_i == `GLT_A_AVG_I_LR) rd_val = i_last;
		else if (wb_adr_i == `GLT_A_AVG_P_LR) rd_val = p_last;
		else if (wb_adr_i == `GLT_A_DELTA_V) rd_val = dv_reg;
		else if (wb_adr_i == `GLT_A_RA0) rd_val = ra_reg[0];
		else if (wb_adr_i == `GLT_A_RA1) rd_val = ra_reg[1];
		else if (wb_adr_i == `GLT_A_DEF_RA) rd_val = def_ra_reg;
		else rd_hit = 1'b0;
	end

	// Bus answer: one cycle after the request, ack or err, then dropped.
	always @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req && rd_hit;
			wb_err_o <= wb_req && !rd_hit;
			if (wb_req && rd_hit && !wb_we_i)
				wb_dat_o <= {{(32-W){1'b0}}, rd_val};
			else
				wb_dat_o <= 32'h00000000;
		end
	end

	// ************************************************************
	// Configuration and measurement registers
	// ************************************************************
	wire [31:0] wm = merge({{(32-W){1'b0}}, rd_val}, wb_dat_i, wb_sel_i);
	always @(posedge clk) begin
		if (rst) begin
			ctrl_reg     <= `GLT_CTRL_RST;
			dsg_th_reg   <= {W{1'b0}};
			chg_th_reg   <= {W{1'b0}};
			quit_i_reg   <= {W{1'b0}};
			dsg_rt_reg   <= 16'h0001;
			chg_rt_reg   <= 16'h0001;
			quit_rt_reg  <= 16'h0001;
			res_chg_reg  <= {W{1'b0}};
			res_nrg_reg  <= {W{1'b0}};
			design_e_reg <= {W{1'b0}};
			host_rt_reg  <= {W{1'b0}};
			user_rt_reg  <= {W{1'b0}};
			min_dv_reg   <= {W{1'b0}};
			def_ra_reg   <= {W{1'b0}};
			meas_i_reg   <= {W{1'b0}};
			meas_v_reg   <= {W{1'b0}};
			slope_reg    <= {W{1'b0}};
			meas_pend_reg <= 1'b0;
		end else begin
			meas_pend_reg <= meas_valid;
			if (wb_wr) begin
				if (wb_adr_i == `GLT_A_CTRL) ctrl_reg <= wm[7:0];
				else if (wb_adr_i == `GLT_A_DSG_TH) dsg_th_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_CHG_TH) chg_th_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_QUIT_I) quit_i_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_DSG_RT) dsg_rt_reg <= wm[15:0];
				else if (wb_adr_i == `GLT_A_CHG_RT) chg_rt_reg <= wm[15:0];
				else if (wb_adr_i == `GLT_A_QUIT_RT) quit_rt_reg <= wm[15:0];
				else if (wb_adr_i == `GLT_A_RES_CHG) res_chg_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_RES_NRG) res_nrg_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_DESIGN_E) design_e_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_HOST_RT) host_rt_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_USER_RT) user_rt_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_MIN_DV) min_dv_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_DEF_RA) def_ra_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_MEAS_I) begin
					meas_i_reg    <= wm[W-1:0];
					meas_pend_reg <= 1'b1;
				end
				else if (wb_adr_i == `GLT_A_MEAS_V) meas_v_reg <= wm[W-1:0];
				else if (wb_adr_i == `GLT_A_SLOPE) slope_reg <= wm[W-1:0];
			end
		end
	end

	// ************************************************************
	// Averaging, classification and spike margin
	// ************************************************************
	always @(posedge clk) begin
		if (rst) begin
			avg_i_reg   <= {W{1'b0}};
			filt_i_reg  <= {W{1'b0}};
			dsg_reg     <= 1'b0;
			chg_reg     <= 1'b0;
			dv_last_reg <= {W{1'b0}};
			dv_var_reg  <= {W{1'b0}};
			dv_reg      <= {W{1'b0}};
			load_value  <= {W{1'b0}};
		end else begin
			load_value <= load_next;
			if (meas_pend_reg) begin
				avg_i_reg <= avg_i_reg + ((meas_i_reg - avg_i_reg) >>> 2);
				dsg_reg   <= dsg_now;
				chg_reg   <= !meas_i_reg[W-1] && (abs_i > chg_th_reg);
			end
			// First-order filter stepped once a second with a 14 s time constant.
			if (sec_tick)
				filt_i_reg <= filt_i_reg + (avg_i_reg - filt_i_reg) / $signed({1'b0, TAU_S});
			if (spike_valid) begin
				dv_last_reg <= $signed(absv(meas_v_reg - avg_i_reg));
				dv_var_reg  <= dv_var_reg + (($signed(absv(meas_v_reg - avg_i_reg)) - dv_var_reg) >>> 3);
			end
			case (dvsel)
			`GLT_DV_STD:  dv_reg <= dv_var_reg;
			`GLT_DV_LAST: dv_reg <= dv_last_reg;
			`GLT_DV_MIN:  dv_reg <= min_dv_reg;
			default:      dv_reg <= dv_reg;
			endcase
		end
	end

	// ************************************************************
	// Relaxation tracking
	// ************************************************************
	// Strobes are gated by the staying condition so none escapes on the exit edge.
	wire relax_stay = relaxed && !(above_s_reg >= quit_rt_reg);
	always @(posedge clk) begin
		if (rst) begin
			sec_cnt_reg   <= 32'h00000000;
			below_s_reg   <= 16'h0000;
			above_s_reg   <= 16'h0000;
			relaxed       <= 1'b0;
			relax_cnt_reg <= 40'h0000000000;
			ocv_take      <= 1'b0;
			ocv_done_reg  <= 1'b0;
			qmax_update   <= 1'b0;
			status_reg    <= 5'h00;
		end else begin
			sec_cnt_reg <= sec_tick ? 32'h00000000 : sec_cnt_reg + 32'h00000001;
			if (!below_q) below_s_reg <= 16'h0000;
			else if (sec_tick && below_s_reg != 16'hFFFF) below_s_reg <= below_s_reg + 16'h0001;
			if (below_q) above_s_reg <= 16'h0000;
			else if (sec_tick && above_s_reg != 16'hFFFF) above_s_reg <= above_s_reg + 16'h0001;
			if (!relaxed && (below_s_reg >= dsg_rt_reg || below_s_reg >= chg_rt_reg))
				relaxed <= 1'b1;
			else if (relaxed && above_s_reg >= quit_rt_reg)
				relaxed <= 1'b0;
			if (!relaxed) begin
				relax_cnt_reg <= 40'h0000000000;
				ocv_done_reg  <= 1'b0;
			end else if (relax_cnt_reg != OCV_CYC)
				relax_cnt_reg <= relax_cnt_reg + 40'h0000000001;
			ocv_take <= relax_stay && relax_cnt_reg == OCV_CYC && !ocv_done_reg && !ocv_take;
			if (ocv_take) ocv_done_reg <= 1'b1;
			qmax_update <= ocv_take && relax_stay && absv(slope_reg) < `GLT_SLOPE_MAX;
			status_reg <= {qmax_update, ocv_done_reg, relaxed, chg_reg, dsg_reg};
		end
	end

	// ************************************************************
	// Capacity, learned status and resistance tables
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_prof
			always @(posedge clk) begin
				if (rst) begin
					qmax_reg[g] <= {W{1'b0}};
					upd_reg[g]  <= 16'h0000;
					ra_reg[g]   <= {W{1'b0}};
				end else if (qmax_update && prof == g) begin
					qmax_reg[g] <= qmax_reg[g] + ((absv(i_last) - qmax_reg[g]) >> 4);
					upd_reg[g]  <= upd_reg[g] | `GLT_UPD_MASK;
					ra_reg[g]   <= absv(dv_reg);
				end else if (wb_wr && wb_adr_i == (g ? `GLT_A_QMAX1 : `GLT_A_QMAX0))
					qmax_reg[g] <= wm[W-1:0];
				else if (wb_wr && wb_adr_i == (g ? `GLT_A_UPD1 : `GLT_A_UPD0))
					upd_reg[g] <= wm[15:0] & `GLT_UPD_MASK;
				else if (wb_wr && wb_adr_i == (g ? `GLT_A_RA1 : `GLT_A_RA0))
					ra_reg[g] <= wm[W-1:0];
			end
		end
	endgenerate
endmodule

// ==== tb/glt_tracker_assertions.sv ====
// Concurrent checks on the bus answers and relaxation outputs of the tracker.
`timescale 1ns/1ps
module glt_tracker_assertions #(
	parameter        W       = 16,
	parameter [31:0] SEC_CYC = 32'h4
) (
	// Clock and reset
	input wire         clk,
	input wire         rst,
	// Wishbone slave
	input wire         wb_cyc_i,
	input wire         wb_stb_i,
	input wire         wb_we_i,
	input wire [7:0]   wb_adr_i,
	input wire [3:0]   wb_sel_i,
	input wire [31:0]  wb_dat_i,
	input wire [31:0]  wb_dat_o,
	input wire         wb_ack_o,
	input wire         wb_err_o,
	// Measurements
	input wire         meas_valid,
	input wire         spike_valid,
	// Results
	input wire [W-1:0] load_value,
	input wire         relaxed,
	input wire         ocv_take,
	input wire         qmax_update
);
	// Saturating age since reset; relaxation can never be entered sooner than one relax second.
	logic [31:0] since_rst;
	always @(posedge clk) begin
		if (rst)
			since_rst <= 32'h0;
		else if (since_rst != 32'hFFFF)
			since_rst <= since_rst + 32'h1;
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence s_answer;
		(wb_ack_o || wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
	endsequence

	a_answer_next: assert property (s_take |=> s_answer)
		else $error("Bus request not answered once after one cycle.");
	a_err_unmapped: assert property ((s_take ##0 wb_adr_i > 8'h6C) |=> wb_err_o && !wb_ack_o && wb_dat_o == 32'h0)
		else $error("Unmapped access not refused.");
	a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
		else $error("Answer without a request.");
	a_dat_quiet: assert property (!wb_ack_o || wb_we_i |-> wb_dat_o == 32'h0)
		else $error("Read data driven outside a read answer.");
	a_ocv_pulse: assert property (ocv_take |=> !ocv_take)
		else $error("Open-circuit reading strobe longer than one cycle.");
	a_ocv_relaxed: assert property (ocv_take |-> relaxed)
		else $error("Open-circuit reading taken while not relaxed.");
	a_qmax_relaxed: assert property (qmax_update |-> relaxed)
		else $error("Capacity update outside relaxation.");
	a_relax_late: assert property ($rose(relaxed) |-> since_rst >= SEC_CYC)
		else $error("Relaxation entered sooner than one relax second.");
	a_exit_hold: assert property ($fell(relaxed) |-> $past(relaxed, 4))
		else $error("Relaxation left without dwelling.");
endmodule

// ==== tb/glt_tracker_tb.sv ====
// Self-checking bench for load model selection, current classification and relax tracking.
`timescale 1ns/1ps
`include "glt_defines.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module glt_tracker_tb;
	localparam int SEC = 4;
	localparam int OCV = 40;
	logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e, rlx_d;
	logic        meas_valid, spike_valid, relaxed, ocv_take, qmax_update;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [15:0] load_value;
	int          num_errors, cmp_count, cycles, qseen, t_rise, ocv_gap, de, hr, ur, am, mi;
	logic [7:0]  rw_adr[$];
	int          rw_val[$];
	int          cur[5] = '{-11, -10, 11, 10, 0};

	glt_tracker #(.W(16), .OCV_CYC(40'h28), .SEC_CYC(32'h4), .TAU_S(8'hE)) glt_tracker_inst (
		.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .meas_valid(meas_valid), .spike_valid(spike_valid),
		.load_value(load_value), .relaxed(relaxed), .ocv_take(ocv_take), .qmax_update(qmax_update)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Watchdog and event log; the gap from relax entry to the reading is kept for a later check.
	always @(posedge clk) begin
		cycles++;
		rlx_d <= relaxed;
		if (relaxed === 1'b1 && rlx_d !== 1'b1)
			t_rise = cycles;
		if (ocv_take === 1'b1)
			ocv_gap = cycles - t_rise;
		if (qmax_update === 1'b1)
			qseen++;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic summarize();
		if (num_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		@(posedge clk);
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
			@(posedge clk);
		q = wb_dat_o;
		e = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk);
	endtask

	// Model of the quarter-step average current, advanced on every sample the bench causes.
	task automatic wr(input logic [7:0] a, input int d);
		if (a == `GLT_A_MEAS_I) begin
			am = am + ((d - am) >>> 2);
			mi = d;
		end
		bus(1'b1, a, 32'(d));
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input int ex);
		bus(1'b0, a, 32'h0);
		`CHK(nm, {16'h0, 16'(ex)}, q)
	endtask

	task automatic pulses(input int k);
		repeat (k) begin
			am = am + ((mi - am) >>> 2);
			meas_valid <= 1'b1;
			@(posedge clk);
			meas_valid <= 1'b0;
			@(posedge clk);
		end
	endtask

	function automatic int pw(input int i, input int v);
		return (i * v) >>> 16;
	endfunction

	function automatic int ab(input int x);
		return (x < 0) ? -x : x;
	endfunction

	initial begin
		rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		meas_valid = 1'b0;
		spike_valid = 1'b0;
		void'($urandom(85));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdc("ctrl", `GLT_A_CTRL, 2);
		rdc("quit time", `GLT_A_QUIT_RT, 1);
		bus(1'b0, 8'h70, 32'h0);
		`CHK("refused", 1'b1, e)
		rw_adr = '{`GLT_A_DSG_TH, `GLT_A_CHG_TH, `GLT_A_RES_CHG, `GLT_A_RES_NRG, `GLT_A_DESIGN_E,
			`GLT_A_HOST_RT, `GLT_A_USER_RT, `GLT_A_MIN_DV, `GLT_A_QMAX0, `GLT_A_QMAX1, `GLT_A_DEF_RA};
		foreach (rw_adr[i]) begin
			rw_val.push_back($urandom_range(0, 32'hFFFF));
			wr(rw_adr[i], rw_val[i] + 32'h5A0000);
		end
		foreach (rw_adr[i])
			rdc("param", rw_adr[i], rw_val[i]);
		wr(`GLT_A_UPD0, 32'hFFFF);
		rdc("learned", `GLT_A_UPD0, 1);
		wr(`GLT_A_DSG_TH, 10);
		wr(`GLT_A_CHG_TH, 10);
		foreach (cur[i]) begin
			wr(`GLT_A_MEAS_I, cur[i]);
			bus(1'b0, `GLT_A_STATUS, 32'h0);
			`CHK("class", (cur[i] < -10) ? 2'h1 : (cur[i] > 10) ? 2'h2 : 2'h0, q[1:0])
		end
		wr(`GLT_A_MEAS_V, 32'h4000);
		repeat (4) wr(`GLT_A_MEAS_I, -100);
		`CHK("load current", 16'(100), load_value)
		wr(`GLT_A_CTRL, 3);
		`CHK("load present", 16'(ab(pw(-100, 32'h4000))), load_value)
		wr(`GLT_A_MEAS_I, 0);
		bus(1'b0, `GLT_A_AVG_I_LR, 32'h0);
		`CHK("avg current", 16'(-100), q[15:0])
		bus(1'b0, `GLT_A_AVG_P_LR, 32'h0);
		`CHK("avg power", 16'(pw(-100, 32'h4000)), q[15:0])
		wr(`GLT_A_CTRL, 1);
		`CHK("load last", 16'(ab(pw(-100, 32'h4000))), load_value)
		wr(`GLT_A_CTRL, 0);
		`CHK("load last current", 16'(100), load_value)
		wr(`GLT_A_CTRL, 5);
		`CHK("load avg power", 16'(ab(pw(am, 32'h4000))), load_value)
		wr(`GLT_A_CTRL, 4);
		`CHK("load avg current", 16'(ab(am)), load_value)
		de = $urandom_range(0, 32'h7FFF);
		hr = $urandom_range(0, 32'h7FFF);
		ur = $urandom_range(0, 32'h7FFF);
		wr(`GLT_A_DESIGN_E, de);
		wr(`GLT_A_HOST_RT, hr);
		wr(`GLT_A_USER_RT, ur);
		for (int k = 0; k < 2; k++)
			for (int s = 4; s < 8; s++) begin
				wr(`GLT_A_CTRL, s * 2 + k);
				`CHK("load sel", 16'((s == 4) ? (k ? de : rw_val[8]) / 5 : (s == 5) ? hr : ur), load_value)
			end
		wr(`GLT_A_MIN_DV, de);
		wr(`GLT_A_CTRL, 32'h23);
		spike_valid <= 1'b1;
		@(posedge clk);
		spike_valid <= 1'b0;
		rdc("delta v", `GLT_A_DELTA_V, de);
		wr(`GLT_A_QUIT_I, 50);
		wr(`GLT_A_DSG_RT, 2);
		wr(`GLT_A_CHG_RT, 3);
		wr(`GLT_A_QUIT_RT, 2);
		wr(`GLT_A_SLOPE, 4);
		wr(`GLT_A_CTRL, 2);
		wr(`GLT_A_MEAS_I, 200);
		pulses(12);
		while (relaxed !== 1'b0)
			@(posedge clk);
		qseen = 0;
		wr(`GLT_A_MEAS_I, 0);
		pulses(12);
		while (ocv_take !== 1'b1)
			@(posedge clk);
		@(posedge clk);
		`CHK("ocv delay", 1'b1, ocv_gap >= OCV - SEC && ocv_gap <= OCV + SEC)
		repeat (10) @(posedge clk);
		`CHK("steep slope", 0, qseen)
		wr(`GLT_A_MEAS_I, 200);
		pulses(1);
		`CHK("relax dwell", 1'b1, relaxed)
		while (relaxed !== 1'b0)
			@(posedge clk);
		wr(`GLT_A_SLOPE, 3);
		wr(`GLT_A_UPD0, 0);
		wr(`GLT_A_MEAS_I, 0);
		pulses(12);
		while (qmax_update !== 1'b1)
			@(posedge clk);
		@(posedge clk);
		rdc("learned set", `GLT_A_UPD0, 1);
		summarize();
	end
endmodule

bind glt_tracker glt_tracker_assertions #(.W(W), .SEC_CYC(SEC_CYC)) glt_tracker_assertions_inst (
	.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .meas_valid(meas_valid), .spike_valid(spike_valid),
	.load_value(load_value), .relaxed(relaxed), .ocv_take(ocv_take), .qmax_update(qmax_update)
);
